// ===== hw/guard_host_map.svh
// register offsets, command codes and bus timing of the guard controller
`ifndef GUARD_HOST_MAP_SVH
`define GUARD_HOST_MAP_SVH

`define REG_CTRL        4'h0
`define REG_SECTOR      4'h1
`define REG_PWD_LO      4'h2
`define REG_PWD_HI      4'h3
`define REG_RESULT      4'h4

`define CTRL_OP_LSB     0
`define CTRL_OP_MSB     3
`define CTRL_BYTE_BIT   4

`define OP_ENTER_NV     4'h0
`define OP_ENTER_PLK    4'h1
`define OP_ENTER_VOL    4'h2
`define OP_ENTER_PWD    4'h3
`define OP_EXIT         4'h4
`define OP_NV_PROG      4'h5
`define OP_NV_CLEAR     4'h6
`define OP_NV_READ      4'h7
`define OP_PLK_PROG     4'h8
`define OP_PLK_READ     4'h9
`define OP_VOL_PROT     4'ha
`define OP_VOL_UNPROT   4'hb
`define OP_VOL_READ     4'hc
`define OP_PWD_READ     4'hd
`define OP_PWD_UNLOCK   4'he

`define ADR_UNLOCK1_X8  26'h0000aaa
`define ADR_UNLOCK2_X8  26'h0000555
`define ADR_UNLOCK1_X16 26'h0000555
`define ADR_UNLOCK2_X16 26'h00002aa
`define ADR_ZERO        26'h0000000

`define D_UNLOCK1       16'h00aa
`define D_UNLOCK2       16'h0055
`define D_SET_NV        16'h00c0
`define D_SET_PLK       16'h0050
`define D_SET_VOL       16'h00e0
`define D_SET_PWD       16'h0060
`define D_EXIT1         16'h0090
`define D_EXIT2         16'h0000
`define D_PROG          16'h00a0
`define D_CLEAR1        16'h0080
`define D_CLEAR2        16'h0030
`define D_GUARD_ON      16'h0000
`define D_GUARD_OFF     16'h0001
`define D_PWD_UNLK1     16'h0025
`define D_PWD_UNLK2     16'h0003
`define D_PWD_UNLK_END  16'h0029

`define PWD_LAST_X8     3'h7
`define PWD_LAST_X16    3'h3

`define CLK_PERIOD_NS   100
`define T_WE_LOW_NS     35
`define T_READ_ACC_NS   70
`define SYNC_STAGES     2
`define WE_CYC  ((`T_WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACC_CYC ((`T_READ_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_CYC  (`ACC_CYC + `SYNC_STAGES)

`define FLASH_AW_MAX    26

`endif

// ===== hw/guard_host_pkg.sv
// types of the sector guard host controller
package guard_host_pkg;
    `include "guard_host_map.svh"

    typedef enum logic [2:0] {SET_NONE, SET_NV, SET_PLK, SET_VOL,
                              SET_PWD} set_e;
    typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE,
                              PH_RECOVER} phase_e;

    typedef struct packed {
        logic                       rd;
        logic [`FLASH_AW_MAX-1:0]   addr;
        logic [15:0]                data;
        logic                       last;
    } cyc_s;

    typedef struct packed {
        phase_e                     phase;
        set_e                       set;
        logic [3:0]                 op;
        logic [3:0]                 k;
        logic [2:0]                 cnt;
        logic                       bm;
        logic                       busy;
        logic                       err;
        logic [`FLASH_AW_MAX-1:0]   sector;
        logic [63:0]                pwd;
        logic [15:0]                result;
        logic [31:0]                rdata;
        logic                       rd_cyc;
        logic                       last;
        logic                       ce_n;
        logic                       oe_n;
        logic                       we_n;
        logic [`FLASH_AW_MAX-1:0]   addr;
        logic [15:0]                dq_o;
        logic                       dq_oe;
        logic                       byte_n;
        logic [15:0]                sync1;
        logic [15:0]                sync2;
    } state_s;
endpackage

// ===== hw/guard_host.sv
// host controller driving the flash sector guard command sequences
//
// Notes on behaviour
// - enter the matching set before guard orders
// - set stays open until two-cycle exit
// - nonvolatile set entry: unlock, unlock, c0
// - persistent lock set entry: unlock, unlock, 50
// - clear all: 80 anywhere, 30 at 00
// - status and password reads are read cycles
// - password portions accepted in any order
// - byte password read: eight reads, 00..07
// - byte unlock: eleven cycles, ends with 29
// - word unlock: seven cycles, words 0..3
// - password bytes 0..7 or words 0..3
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps

module guard_host #(
    parameter int AW = 23
) (
    input  wire logic           core_clk,
    input  wire logic           rstn,
    input  wire logic [3:0]     reg_addr,
    input  wire logic [31:0]    reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output logic      [31:0]    reg_rdata,
    output logic                flash_ce_n,
    output logic                flash_oe_n,
    output logic                flash_we_n,
    output logic                flash_byte_n,
    output logic      [AW-1:0]  flash_addr,
    input  wire logic [15:0]    flash_dq_i,
    output logic      [15:0]    flash_dq_o,
    output logic                flash_dq_oe
);
    import guard_host_pkg::*;

    localparam logic [2:0] WE_LEN = 3'(`WE_CYC);
    localparam logic [2:0] RD_LEN = 3'(`RD_CYC);

    generate
        if (AW < 16 || AW > `FLASH_AW_MAX || `RD_CYC > 7 || `WE_CYC < 1)
        begin : g_bad_cfg
            $error("guard_host: unsupported configuration");
        end
    endgenerate

    state_s q;
    state_s n;

    // set that an order needs before it may run
    function automatic set_e need_set(input logic [3:0] op);
        case (op)
            `OP_NV_PROG, `OP_NV_CLEAR, `OP_NV_READ: need_set = SET_NV;
            `OP_PLK_PROG, `OP_PLK_READ:             need_set = SET_PLK;
            `OP_VOL_PROT, `OP_VOL_UNPROT,
            `OP_VOL_READ:                           need_set = SET_VOL;
            `OP_PWD_READ, `OP_PWD_UNLOCK:           need_set = SET_PWD;
            default:                                need_set = SET_NONE;
        endcase
    endfunction

    function automatic logic order_ok(input logic [3:0] op,
                                      input set_e cur);
        case (op)
            `OP_ENTER_NV, `OP_ENTER_PLK,
            `OP_ENTER_VOL, `OP_ENTER_PWD: order_ok = (cur == SET_NONE);
            `OP_EXIT:                     order_ok = (cur != SET_NONE);
            4'hf:                         order_ok = 1'b0;
            default:                      order_ok = (cur == need_set(op));
        endcase
    endfunction

    // bus cycle k of an order
    function automatic cyc_s step(input logic [3:0] op,
                                  input logic [3:0] k,
                                  input logic bm,
                                  input logic [`FLASH_AW_MAX-1:0] sec,
                                  input logic [63:0] pwd);
        logic [`FLASH_AW_MAX-1:0] a1;
        logic [`FLASH_AW_MAX-1:0] a2;
        logic [2:0]               plast;
        logic [2:0]               idx;
        logic [15:0]              portion;
        cyc_s                     c;
        a1 = bm ? `ADR_UNLOCK1_X8 : `ADR_UNLOCK1_X16;
        a2 = bm ? `ADR_UNLOCK2_X8 : `ADR_UNLOCK2_X16;
        plast = bm ? `PWD_LAST_X8 : `PWD_LAST_X16;
        idx = 3'(k - 4'h2);
        portion = bm ? {8'h00, pwd[{idx, 3'h0} +: 8]}
                     : pwd[{idx[1:0], 4'h0} +: 16];
        c = '{rd: 1'b0, addr: `ADR_ZERO, data: `D_EXIT2, last: 1'b0};
        case (op)
            `OP_ENTER_NV, `OP_ENTER_PLK, `OP_ENTER_VOL, `OP_ENTER_PWD: begin
                c.addr = (k == 4'h1) ? a2 : a1;
                c.data = (k == 4'h0) ? `D_UNLOCK1 : `D_UNLOCK2;
                if (k == 4'h2) begin
                    c.last = 1'b1;
                    case (op)
                        `OP_ENTER_NV:  c.data = `D_SET_NV;
                        `OP_ENTER_PLK: c.data = `D_SET_PLK;
                        `OP_ENTER_VOL: c.data = `D_SET_VOL;
                        default:       c.data = `D_SET_PWD;
                    endcase
                end
            end
            `OP_EXIT: begin
                c.data = (k == 4'h0) ? `D_EXIT1 : `D_EXIT2;
                c.last = (k == 4'h1);
            end
            `OP_NV_CLEAR: begin
                c.data = (k == 4'h0) ? `D_CLEAR1 : `D_CLEAR2;
                c.last = (k == 4'h1);
            end
            `OP_NV_PROG, `OP_PLK_PROG, `OP_VOL_PROT, `OP_VOL_UNPROT: begin
                c.data = `D_PROG;
                if (k == 4'h1) begin
                    c.last = 1'b1;
                    c.addr = (op == `OP_PLK_PROG) ? `ADR_ZERO : sec;
                    c.data = (op == `OP_VOL_UNPROT) ? `D_GUARD_OFF
                                                    : `D_GUARD_ON;
                end
            end
            `OP_NV_READ, `OP_VOL_READ, `OP_PLK_READ: begin
                c.rd = 1'b1;
                c.addr = (op == `OP_PLK_READ) ? `ADR_ZERO : sec;
                c.last = 1'b1;
            end
            `OP_PWD_READ: begin
                c.rd = 1'b1;
                c.addr = `FLASH_AW_MAX'(k);
                c.last = (k[2:0] == plast);
            end
            `OP_PWD_UNLOCK: begin
                if (k == 4'h0) begin
                    c.data = `D_PWD_UNLK1;
                end else if (k == 4'h1) begin
                    c.data = `D_PWD_UNLK2;
                end else if (k <= {1'b0, plast} + 4'h2) begin
                    c.addr = `FLASH_AW_MAX'(idx);
                    c.data = portion;
                end else begin
                    c.data = `D_PWD_UNLK_END;
                    c.last = 1'b1;
                end
            end
            default: c.last = 1'b1;
        endcase
        step = c;
    endfunction

    always_comb begin
        cyc_s c;
        c = step(q.op, q.k, q.bm, q.sector, q.pwd);
        n = q;
        n.sync1 = flash_dq_i;
        n.sync2 = q.sync1;
        n.rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL:   n.rdata = {26'h0, q.set, q.bm, q.err, q.busy};
                `REG_SECTOR: n.rdata = 32'(q.sector);
                `REG_PWD_LO: n.rdata = q.pwd[31:0];
                `REG_PWD_HI: n.rdata = q.pwd[63:32];
                `REG_RESULT: n.rdata = {16'h0, q.result};
                default:     n.rdata = 32'h0;
            endcase
        end
        if (reg_wr && q.phase == PH_IDLE) begin
            case (reg_addr)
                `REG_SECTOR: n.sector = reg_wdata[`FLASH_AW_MAX-1:0];
                `REG_PWD_LO: n.pwd[31:0] = reg_wdata;
                `REG_PWD_HI: n.pwd[63:32] = reg_wdata;
                default:     n.sector = q.sector;
            endcase
        end
        case (q.phase)
            PH_IDLE: begin
                if (reg_wr && reg_addr == `REG_CTRL) begin
                    n.op = reg_wdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
                    n.bm = reg_wdata[`CTRL_BYTE_BIT];
                    n.byte_n = !reg_wdata[`CTRL_BYTE_BIT];
                    n.k = 4'h0;
                    // refused order leaves set untouched but still updates the byte pin
                    if (order_ok(n.op, q.set)) begin
                        n.err = 1'b0;
                        n.busy = 1'b1;
                        n.phase = PH_SETUP;
                    end else begin
                        n.err = 1'b1;
                    end
                end
            end
            PH_SETUP: begin
                n.ce_n = 1'b0;
                n.addr = c.addr;
                n.rd_cyc = c.rd;
                n.last = c.last;
                // command codes carry a zero upper byte, x16 words do not
                n.dq_o = c.data;
                n.dq_oe = !c.rd;
                n.oe_n = !c.rd;
                n.we_n = c.rd;
                n.cnt = 3'h0;
                n.phase = PH_STROBE;
            end
            PH_STROBE: begin
                n.cnt = q.cnt + 3'h1;
                if (n.cnt == (q.rd_cyc ? RD_LEN : WE_LEN)) begin
                    n.oe_n = 1'b1;
                    n.we_n = 1'b1;
                    n.phase = PH_RECOVER;
                    if (q.rd_cyc) begin
                        n.result = q.sync2;
                        if (q.op == `OP_PWD_READ) begin
                            if (q.bm) begin
                                n.pwd[{q.k[2:0], 3'h0} +: 8] = q.sync2[7:0];
                            end else begin
                                n.pwd[{q.k[1:0], 4'h0} +: 16] = q.sync2;
                            end
                        end
                    end
                end
            end
            PH_RECOVER: begin
                n.ce_n = 1'b1;
                n.dq_oe = 1'b0;
                if (q.last) begin
                    n.busy = 1'b0;
                    n.phase = PH_IDLE;
                    case (q.op)
                        `OP_ENTER_NV:  n.set = SET_NV;
                        `OP_ENTER_PLK: n.set = SET_PLK;
                        `OP_ENTER_VOL: n.set = SET_VOL;
                        `OP_ENTER_PWD: n.set = SET_PWD;
                        `OP_EXIT:      n.set = SET_NONE;
                        default:       n.set = q.set;
                    endcase
                end else begin
                    n.k = q.k + 4'h1;
                    n.phase = PH_SETUP;
                end
            end
            default: n.phase = PH_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{phase: PH_IDLE, set: SET_NONE, ce_n: 1'b1, oe_n: 1'b1,
                   we_n: 1'b1, byte_n: 1'b1, default: '0};
        end else begin
            q <= n;
        end
    end

    assign reg_rdata    = q.rdata;
    assign flash_ce_n   = q.ce_n;
    assign flash_oe_n   = q.oe_n;
    assign flash_we_n   = q.we_n;
    assign flash_byte_n = q.byte_n;
    assign flash_addr   = q.addr[AW-1:0];
    assign flash_dq_o   = q.dq_o;
    assign flash_dq_oe  = q.dq_oe;

    wire wr_go = reg_wr && reg_addr == `REG_CTRL && q.phase == PH_IDLE;
    wire we_low = !q.we_n;

    a_strobe_excl: assert property (@(posedge core_clk) disable iff (!rstn)
        !(!q.we_n && !q.oe_n)) else $error("both strobes low");
    a_read_nodrive: assert property (@(posedge core_clk) disable iff (!rstn)
        !q.oe_n |-> !q.dq_oe) else $error("driving during read");
    a_upper_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        q.dq_oe && !(q.op == `OP_PWD_UNLOCK && q.k > 4'h1 && !q.last)
        |-> q.dq_o[15:8] == 8'h00)
        else $error("upper byte driven");
    a_refuse_early: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_go && q.set == SET_NONE
        && need_set(reg_wdata[3:0]) != SET_NONE
        |=> q.err && !q.busy && q.phase == PH_IDLE)
        else $error("order run outside its set");
    a_exit_closes: assert property (@(posedge core_clk) disable iff (!rstn)
        q.phase == PH_RECOVER && q.last && q.op == `OP_EXIT
        |=> q.set == SET_NONE && !q.busy) else $error("exit kept set");
    a_nv_code: assert property (@(posedge core_clk) disable iff (!rstn)
        we_low && q.op == `OP_ENTER_NV && q.k == 4'h2
        |-> q.dq_o == `D_SET_NV) else $error("bad nv entry code");
    a_plk_code: assert property (@(posedge core_clk) disable iff (!rstn)
        we_low && q.op == `OP_ENTER_PLK && q.k == 4'h2
        |-> q.dq_o == `D_SET_PLK) else $error("bad plk entry code");
    a_clear_pair: assert property (@(posedge core_clk) disable iff (!rstn)
        we_low && q.op == `OP_NV_CLEAR && q.k == 4'h1
        |-> q.addr == `ADR_ZERO && q.dq_o == `D_CLEAR2)
        else $error("bad clear cycle");
    a_vol_value: assert property (@(posedge core_clk) disable iff (!rstn)
        we_low && q.k == 4'h1
        && (q.op == `OP_VOL_PROT || q.op == `OP_VOL_UNPROT)
        |-> q.dq_o == ((q.op == `OP_VOL_UNPROT) ? `D_GUARD_OFF
                                                : `D_GUARD_ON))
        else $error("bad volatile value");
    a_unlock_end: assert property (@(posedge core_clk) disable iff (!rstn)
        we_low && q.last && q.op == `OP_PWD_UNLOCK
        |-> q.dq_o == `D_PWD_UNLK_END && q.k == (q.bm ? 4'ha : 4'h6))
        else $error("bad unlock end");
    a_we_width: assert property (@(posedge core_clk) disable iff (!rstn)
        $fell(q.we_n) |-> !q.we_n [*1] ##1 q.we_n)
        else $error("write strobe width");

    c_enter_nv: cover property (@(posedge core_clk) disable iff (!rstn)
        q.phase == PH_RECOVER && q.last && q.op == `OP_ENTER_NV);
    c_pwd_read: cover property (@(posedge core_clk) disable iff (!rstn)
        q.phase == PH_RECOVER && q.last && q.op == `OP_PWD_READ);
    c_unlock: cover property (@(posedge core_clk) disable iff (!rstn)
        q.phase == PH_RECOVER && q.last && q.op == `OP_PWD_UNLOCK);
    c_refused: cover property (@(posedge core_clk) disable iff (!rstn)
        $rose(q.err));
endmodule

// ===== tb/guard_flash_model.sv
// behavioural flash model holding the sector guard state
`timescale 1ns/10ps
module guard_flash_model #(
    parameter int          AW  = 23,
    parameter logic [63:0] PWD = 64'h0f1e2d3c4b5a6978
) (
    input  wire logic          core_clk,
    input  wire logic          ce_n,
    input  wire logic          oe_n,
    input  wire logic          we_n,
    input  wire logic          byte_n,
    input  wire logic [AW-1:0] addr,
    input  wire logic [15:0]   dq_in,
    input  wire logic          dq_oe,
    output logic      [15:0]   dq_out
);
    logic [2:0]   set;
    logic [3:0]   step;
    logic [127:0] nv;
    logic [127:0] vol;
    logic         lock_n;
    logic [7:0]   seen;
    logic         ok;
    logic [15:0]  rdat;
    logic [15:0]  last;
    logic [6:0]   sec;
    logic [7:0]   d;
    logic [11:0]  ua;
    logic [11:0]  ub;
    initial begin
        set = 0;
        step = 0;
        nv = '1;
        vol = '1;
        lock_n = 1'b1;
        seen = 0;
        ok = 0;
        last = 0;
    end
    assign sec = addr[AW-1:AW-7];
    assign d   = dq_in[7:0];
    assign ua  = byte_n ? 12'h555 : 12'haaa;
    assign ub  = byte_n ? 12'h2aa : 12'h555;
    // an unexpected cycle drops back to step 0 untouched, except in the portion step, which takes any cycle but 29 as a portion
    always @(posedge we_n) if (ce_n === 1'b0 && dq_oe === 1'b1) begin
        case (step)
        4'd0: if (d == 8'haa && addr[11:0] == ua) step = 1;
              else if (set != 0 && d == 8'h90) step = 5;
              else if (set != 0 && d == 8'ha0) step = 6;
              else if (set == 1 && d == 8'h80) step = 7;
              else if (set == 4 && d == 8'h25) step = 8;
        4'd1: step = (d == 8'h55 && addr[11:0] == ub) ? 4'd2 : 4'd0;
        4'd2: begin
            if (addr[11:0] == ua && set == 0) begin
                if (d == 8'hc0) set = 1;
                if (d == 8'h50) set = 2;
                if (d == 8'he0) set = 3;
                if (d == 8'h60) set = 4;
            end
            step = 0;
        end
        4'd5: begin
            if (d == 8'h00) set = 0;
            step = 0;
        end
        4'd6: begin
            if (set == 1 && d == 8'h00 && lock_n) nv[sec] = 0;
            if (set == 2 && d == 8'h00) lock_n = 0;
            if (set == 3 && d[7:1] == 0) vol[sec] = d[0];
            step = 0;
        end
        4'd7: begin
            if (d == 8'h30 && addr == 0 && lock_n) nv = '1;
            step = 0;
        end
        4'd8: begin
            step = (d == 8'h03) ? 4'd9 : 4'd0;
            seen = 0;
            ok = 1;
        end
        default: if (d == 8'h29) begin
            if (ok && &seen) lock_n = 1;
            step = 0;
        end else if (byte_n) begin
            seen[2*addr[1:0] +: 2] = 2'b11;
            if (dq_in != PWD[16*addr[1:0] +: 16]) ok = 0;
        end else begin
            seen[addr[2:0]] = 1;
            if (d != PWD[8*addr[2:0] +: 8]) ok = 0;
        end
        endcase
    end
    // open set answers with guard data instead of array data
    always_comb begin
        case (set)
        3'd1: rdat = {15'h0, nv[sec]};
        3'd2: rdat = {15'h0, lock_n};
        3'd3: rdat = {15'h0, vol[sec]};
        3'd4: rdat = byte_n ? PWD[16*addr[1:0] +: 16]
                            : {8'h00, PWD[8*addr[2:0] +: 8]};
        default: rdat = addr[15:0] ^ 16'h5a5a;
        endcase
    end
    always @(posedge core_clk) if (!ce_n && !oe_n) last <= rdat;
    assign dq_out = (!ce_n && !oe_n) ? rdat : ~last;
endmodule

// ===== tb/guard_host_tb.sv
// self-checking bench of the sector guard host controller
`timescale 1ns/10ps
`include "guard_host_map.svh"
module guard_host_tb;
    localparam logic [63:0] PWD = 64'h0f1e2d3c4b5a6978;
    logic        core_clk, rstn, reg_wr, reg_rd;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        ce_n, oe_n, we_n, byte_n, dq_oe;
    logic [22:0] faddr;
    logic [15:0] dq_i, dq_o;
    int          miscompares = 0;
    int          total_checks = 0;
    guard_host #(.AW(23)) dut (.core_clk(core_clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_byte_n(byte_n),
        .flash_addr(faddr), .flash_dq_i(dq_i), .flash_dq_o(dq_o),
        .flash_dq_oe(dq_oe));
    guard_flash_model #(.AW(23), .PWD(PWD)) u_flash (.core_clk(core_clk),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .byte_n(byte_n),
        .addr(faddr), .dq_in(dq_o), .dq_oe(dq_oe), .dq_out(dq_i));
    always #50 core_clk = ~core_clk;
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    // one order, then poll busy under a bound
    task automatic order(input logic [3:0] op, input logic bm,
                         input logic [25:0] sec);
        logic [31:0] st;
        int          n;
        wr(`REG_SECTOR, {6'h0, sec});
        wr(`REG_CTRL, {27'h0, bm, op});
        n = 0;
        do begin
            rd(`REG_CTRL, st);
            n++;
        end while (st[0] !== 1'b0 && n < 300);
        if (st[0] !== 1'b0) begin
            miscompares++;
            $display("[ERR] %0t busy never cleared", $time);
            complete_run();
        end
    endtask
    task automatic chk_st(input logic [2:0] s, input logic b, e);
        logic [31:0] v;
        rd(`REG_CTRL, v);
        chk({27'h0, v[5:1]}, {27'h0, s, b, e}, "status");
    endtask
    task automatic res(input logic [25:0] sec, input logic [15:0] e);
        logic [31:0] v;
        rd(`REG_RESULT, v);
        chk({16'h0, v[15:0]}, {16'h0, e}, "result");
    endtask
    task automatic t_reset;
        logic [31:0] v;
        chk({28'h0, ce_n, oe_n, we_n, dq_oe}, 32'he, "idle pins");
        chk({31'h0, byte_n}, 32'h1, "byte pin idle");
        rd(4'h5, v);
        chk(v, 32'h0, "unmapped read");
        chk_st(3'd0, 1'b0, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_nv;
        order(`OP_NV_PROG, 1'b1, 26'h123456);
        chk_st(3'd0, 1'b1, 1'b1);
        chk({31'h0, byte_n}, 32'h0, "byte pin");
        order(`OP_ENTER_NV, 1'b1, 26'h0);
        chk_st(3'd1, 1'b1, 1'b0);
        chk({29'h0, u_flash.set}, 32'h1, "flash set");
        order(`OP_NV_PROG, 1'b1, 26'h120000);
        order(`OP_NV_READ, 1'b1, 26'h12ffff);
        res(26'h12ffff, 16'h0000);
        order(`OP_NV_READ, 1'b1, 26'h130000);
        res(26'h130000, 16'h0001);
        order(`OP_ENTER_VOL, 1'b1, 26'h0);
        chk_st(3'd1, 1'b1, 1'b1);
        order(`OP_NV_CLEAR, 1'b1, 26'h0);
        order(`OP_NV_READ, 1'b1, 26'h120000);
        res(26'h120000, 16'h0001);
        order(`OP_EXIT, 1'b1, 26'h0);
        chk_st(3'd0, 1'b1, 1'b0);
        chk({29'h0, u_flash.set}, 32'h0, "flash set");
        $display("test nonvolatile done");
    endtask
    task automatic t_plk;
        order(`OP_ENTER_PLK, 1'b0, 26'h0);
        chk_st(3'd2, 1'b0, 1'b0);
        order(`OP_PLK_PROG, 1'b0, 26'h0);
        order(`OP_PLK_READ, 1'b0, 26'h0);
        res(26'h0, 16'h0000);
        order(`OP_EXIT, 1'b0, 26'h0);
        order(`OP_ENTER_NV, 1'b0, 26'h0);
        order(`OP_NV_PROG, 1'b0, 26'h050000);
        order(`OP_NV_READ, 1'b0, 26'h05ffff);
        res(26'h05ffff, 16'h0001);
        order(`OP_EXIT, 1'b0, 26'h0);
        $display("test persistent lock done");
    endtask
    task automatic t_vol;
        order(`OP_ENTER_VOL, 1'b1, 26'h0);
        chk_st(3'd3, 1'b1, 1'b0);
        order(`OP_VOL_PROT, 1'b1, 26'h070010);
        order(`OP_VOL_READ, 1'b1, 26'h07abcd);
        res(26'h07abcd, 16'h0000);
        order(`OP_VOL_UNPROT, 1'b1, 26'h070000);
        order(`OP_VOL_READ, 1'b1, 26'h07abcd);
        res(26'h07abcd, 16'h0001);
        order(`OP_EXIT, 1'b1, 26'h0);
        $display("test volatile done");
    endtask
    task automatic t_pwd;
        logic [31:0] lo, hi;
        order(`OP_ENTER_PWD, 1'b1, 26'h0);
        order(`OP_PWD_READ, 1'b1, 26'h0);
        rd(`REG_PWD_LO, lo);
        rd(`REG_PWD_HI, hi);
        chk(lo, PWD[31:0], "password low");
        chk(hi, PWD[63:32], "password high");
        wr(`REG_PWD_LO, PWD[31:0] ^ 32'h0100);
        order(`OP_PWD_UNLOCK, 1'b1, 26'h0);
        chk({31'h0, u_flash.lock_n}, 32'h0, "lock kept");
        wr(`REG_PWD_LO, PWD[31:0]);
        order(`OP_PWD_UNLOCK, 1'b1, 26'h0);
        chk({31'h0, u_flash.lock_n}, 32'h1, "lock freed");
        wr(`REG_PWD_LO, 32'h0);
        wr(`REG_PWD_HI, 32'h0);
        order(`OP_PWD_READ, 1'b0, 26'h0);
        rd(`REG_PWD_HI, hi);
        chk(hi, PWD[63:32], "word password");
        order(`OP_EXIT, 1'b0, 26'h0);
        chk_st(3'd0, 1'b0, 1'b0);
        order(`OP_ENTER_PLK, 1'b0, 26'h0);
        order(`OP_PLK_PROG, 1'b0, 26'h0);
        order(`OP_EXIT, 1'b0, 26'h0);
        chk({31'h0, u_flash.lock_n}, 32'h0, "relocked");
        order(`OP_ENTER_PWD, 1'b0, 26'h0);
        order(`OP_PWD_UNLOCK, 1'b0, 26'h0);
        chk({31'h0, u_flash.lock_n}, 32'h1, "word unlock");
        order(`OP_EXIT, 1'b0, 26'h0);
        $display("test password done");
    endtask
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        #1;
        t_reset();
        t_nv();
        t_plk();
        t_vol();
        t_pwd();
        complete_run();
    end
endmodule
